/* File: rwd_base_model.sv */
// Base timer tick source: one tick every second cycle while running
`timescale 1ns/1ps
module rwd_base_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  output logic baseTick
);
  logic phase_reg;
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      phase_reg <= 1'b0;
      baseTick <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      baseTick <= phase_reg;
    end
  end
endmodule

/* File: rwd_bus_slave.sv */
// Avalon-MM slave front end with one wait cycle per access
`timescale 1ns/1ps
module rwd_bus_slave
  import rwd_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  rwd_link_if.bus link
);
  rwd_bus_state_type state_reg;
  rwd_bus_state_type state_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic request;

  assign request = avsRead | avsWrite;
  assign link.address = avsAddress;
  assign link.writeData = avsWritedata;
  assign link.byteEnable = avsByteenable;
  assign link.isWrite = avsWrite;
  // Read value is captured in the first cycle, answered in the second
  assign link.readSample = avsRead & (state_reg == RWD_BUS_IDLE);
  assign link.accept = request & (state_reg == RWD_BUS_ANSWER);
  assign avsWaitrequest = request & (state_reg == RWD_BUS_IDLE);
  assign avsReaddata = readdata_reg;

  always_comb begin
    state_next = RWD_BUS_IDLE;
    readdata_next = readdata_reg;
    case (state_reg)
      RWD_BUS_IDLE: begin
        if (request) begin
          state_next = RWD_BUS_ANSWER;
        end
        if (link.readSample) begin
          readdata_next = link.readValue;
        end
      end
      RWD_BUS_ANSWER: state_next = RWD_BUS_IDLE;
      default: state_next = RWD_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= RWD_BUS_IDLE;
      readdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      readdata_reg <= readdata_next;
    end
  end
endmodule

/* File: rwd_cfg.svh */
// Register map, field positions, reset values and timing counts
`ifndef RWD_CFG_SVH
`define RWD_CFG_SVH

`define RWD_ADDR_W 16
`define RWD_DATA_W 32

`define RWD_OFS_CONTROL 16'h7f0c
`define RWD_OFS_CLEAR 16'h7f10
`define RWD_OFS_IRQ_STATUS 16'h7f14
`define RWD_OFS_IRQ_MASK 16'h7f18

`define RWD_BIT_START 0
`define RWD_BIT_RUNAWAY 1
`define RWD_BIT_SPARE 2
`define RWD_BIT_HALT 3
`define RWD_BIT_RSTFLAG 4
`define RWD_BIT_ACTION 5

`define RWD_CONTROL_RESET 8'h00
`define RWD_CONTROL_WMASK 8'h3f

`define RWD_EVT_RUNAWAY 0
`define RWD_EVT_WDRESET 1
`define RWD_EVT_W 2

`define RWD_PRESCALE_FAST 32
`define RWD_PRESCALE_SLOW 8192
`define RWD_STAGE_W 3
`define RWD_RUNAWAY_VECTOR 24'h00_8000

`endif

/* File: rwd_checker_assertions.sv */
// Port-level concurrent checks for the runaway watchdog
`timescale 1ns/1ps
module rwd_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [15:0] avsAddress,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic baseTick,
  input wire logic baseTimerRun,
  input wire logic chipResetRequest,
  input wire logic runawayInterrupt,
  input wire logic [23:0] runawayVector
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_first_wait;
    $rose(avsRead) |-> avsWaitrequest;
  endproperty
  a_first_wait: assert property (p_first_wait)
    else $error("waitrequest low in first read cycle");
  property p_answer;
    (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered in second cycle");
  property p_fixed_bits;
    avsRead && !avsWaitrequest && avsAddress == 16'h7f0c
      |-> avsReaddata[7:6] == 2'b00;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("control bits 7..6 read nonzero");
  property p_vector;
    !$past(reset) |-> runawayVector == 24'h00_8000;
  endproperty
  a_vector: assert property (p_vector)
    else $error("runaway vector wrong");
  property p_reset_pulse;
    chipResetRequest |=> !chipResetRequest;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset request longer than one cycle");
  property p_int_pulse;
    runawayInterrupt |=> !runawayInterrupt;
  endproperty
  a_int_pulse: assert property (p_int_pulse)
    else $error("interrupt longer than one cycle");
  property p_exclusive;
    !(chipResetRequest && runawayInterrupt);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("reset and interrupt together");
  property p_int_tick;
    runawayInterrupt |-> $past(baseTick, 2) && $past(baseTimerRun, 2);
  endproperty
  a_int_tick: assert property (p_int_tick)
    else $error("interrupt without a counted tick");
endmodule

bind rwd_runaway_watchdog rwd_checker chk_u (.clock(clock), .reset(reset),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsAddress(avsAddress),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
  .baseTick(baseTick), .baseTimerRun(baseTimerRun),
  .chipResetRequest(chipResetRequest),
  .runawayInterrupt(runawayInterrupt), .runawayVector(runawayVector));

/* File: rwd_link_if.sv */
// Signals between the watchdog core and its bus and counter helpers
`timescale 1ns/1ps
interface rwd_link_if;
  logic [15:0] address;
  logic [31:0] writeData;
  logic [3:0] byteEnable;
  logic isWrite;
  logic readSample;
  logic accept;
  logic [31:0] readValue;
  logic running;
  logic restart;
  logic tickEnable;
  logic fastMode;
  logic overflow;

  modport bus (
    output address,
    output writeData,
    output byteEnable,
    output isWrite,
    output readSample,
    output accept,
    input readValue
  );

  modport core (
    input address,
    input writeData,
    input byteEnable,
    input isWrite,
    input readSample,
    input accept,
    output readValue,
    output running,
    output restart,
    output tickEnable,
    output fastMode,
    input overflow
  );

  modport count (
    input running,
    input restart,
    input tickEnable,
    input fastMode,
    output overflow
  );
endinterface

/* File: rwd_pkg.sv */
// Shared types of the runaway watchdog
package rwd_pkg;

  typedef enum logic {
    RWD_BUS_IDLE,
    RWD_BUS_ANSWER
  } rwd_bus_state_type;

  typedef struct packed {
    logic [1:0] fixed;
    logic actionSelect;
    logic resetFlag;
    logic haltSelect;
    logic spareFlag;
    logic runawayFlag;
    logic start;
  } rwd_control_type;

endpackage

/* File: rwd_runaway_watchdog.sv */
// Runaway watchdog: control register, runaway actions and bus registers
`timescale 1ns/1ps
`include "rwd_cfg.svh"
module rwd_runaway_watchdog
  import rwd_pkg::*;
#(
  parameter int PRESCALE_FAST = `RWD_PRESCALE_FAST,
  parameter int PRESCALE_SLOW = `RWD_PRESCALE_SLOW,
  parameter int STAGE_W = `RWD_STAGE_W
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic baseTick,
  input wire logic baseTimerRun,
  input wire logic baseOscEnabled,
  input wire logic baseFastSelect,
  input wire logic [1:0] baseCountSelect,
  input wire logic standbyEnter,
  input wire logic resetInstruction,
  output logic chipResetRequest,
  output logic runawayInterrupt,
  output logic [23:0] runawayVector,
  output logic irq
);
  rwd_link_if link ();

  rwd_control_type control_reg;
  rwd_control_type control_next;
  logic [`RWD_EVT_W-1:0] status_reg;
  logic [`RWD_EVT_W-1:0] status_next;
  logic [`RWD_EVT_W-1:0] mask_reg;
  logic [`RWD_EVT_W-1:0] mask_next;
  logic [`RWD_EVT_W-1:0] seen_reg;
  logic [`RWD_EVT_W-1:0] seen_next;
  logic chipReset_reg;
  logic chipReset_next;
  logic interrupt_reg;
  logic interrupt_next;
  logic [23:0] vector_reg;
  logic [23:0] vector_next;
  logic irq_reg;
  logic irq_next;
  logic restart_reg;
  logic restart_next;

  logic writeControl;
  logic writeClear;
  logic writeMask;
  logic readStatus;
  logic sampleStatus;
  logic watchdogReset;
  logic runawayEvent;
  logic [7:0] newControl;

  function automatic logic hits(input logic [15:0] addr,
                                input logic [15:0] ofs);
    hits = (addr == ofs);
  endfunction

  function automatic logic [31:0] readMux(input logic [15:0] addr,
                                          input rwd_control_type ctl,
                                          input logic [1:0] sts,
                                          input logic [1:0] msk);
    readMux = 32'h0000_0000;
    if (hits(addr, `RWD_OFS_CONTROL)) begin
      readMux = {24'h00_0000, 2'b00, ctl[5:0]};
    end else if (hits(addr, `RWD_OFS_IRQ_STATUS)) begin
      readMux = {30'h0000_0000, sts};
    end else if (hits(addr, `RWD_OFS_IRQ_MASK)) begin
      readMux = {30'h0000_0000, msk};
    end
  endfunction

  rwd_bus_slave u_bus (
    .clock(clock),
    .reset(reset),
    .avsAddress(avsAddress),
    .avsRead(avsRead),
    .avsWrite(avsWrite),
    .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest),
    .link(link.bus)
  );

  rwd_tick_counter #(
    .PRESCALE_FAST(PRESCALE_FAST),
    .PRESCALE_SLOW(PRESCALE_SLOW),
    .STAGE_W(STAGE_W)
  ) u_count (
    .clock(clock),
    .reset(reset),
    .baseTick(baseTick),
    .link(link.count)
  );

  assign link.readValue = readMux(link.address, control_reg,
                                  status_reg, mask_reg);
  assign link.running = control_reg.start;
  assign link.restart = restart_reg;
  assign link.tickEnable = baseTimerRun;
  // fast period only with fast select and count 00 or 01
  assign link.fastMode = baseFastSelect & ~baseCountSelect[1];

  assign writeControl = link.accept & link.isWrite & link.byteEnable[0]
                        & hits(link.address, `RWD_OFS_CONTROL);
  // clear command is a write of 1 to bit 0
  assign writeClear = link.accept & link.isWrite & link.byteEnable[0]
                      & hits(link.address, `RWD_OFS_CLEAR)
                      & link.writeData[`RWD_BIT_START];
  assign writeMask = link.accept & link.isWrite & link.byteEnable[0]
                     & hits(link.address, `RWD_OFS_IRQ_MASK);
  assign readStatus = link.accept & ~link.isWrite
                      & hits(link.address, `RWD_OFS_IRQ_STATUS);
  assign sampleStatus = link.readSample
                        & hits(link.address, `RWD_OFS_IRQ_STATUS);
  assign newControl = link.writeData[7:0] & `RWD_CONTROL_WMASK;

  assign chipResetRequest = chipReset_reg;
  assign runawayInterrupt = interrupt_reg;
  assign runawayVector = vector_reg;
  assign irq = irq_reg;

  always_comb begin
    control_next = control_reg;
    watchdogReset = 1'b0;
    runawayEvent = 1'b0;
    restart_next = 1'b0;
    control_next.fixed = 2'b00;
    if (resetInstruction) begin
      control_next.runawayFlag = 1'b0;
      control_next.start = 1'b0;
    end else if (control_reg.start && link.overflow) begin
      control_next.runawayFlag = 1'b1;
      // Counter wraps to zero itself; a late restart would drop a tick
      // action select chooses the response
      if (control_reg.actionSelect) begin
        // reset mode keeps bits 5, 3 and 2 and sets bit 4
        watchdogReset = 1'b1;
        control_next.resetFlag = 1'b1;
        control_next.runawayFlag = 1'b0;
        control_next.start = 1'b0;
      end else begin
        // interrupt mode keeps the run state
        runawayEvent = 1'b1;
      end
    end else if (control_reg.start) begin
      if (standbyEnter && control_reg.haltSelect) begin
        control_next.start = 1'b0;
      end
      // counter restart only by the clear command
      restart_next = writeClear;
    end else if (writeControl) begin
      // spare flag stored with no effect
      control_next = rwd_control_type'(newControl);
      if (newControl[`RWD_BIT_START]) begin
        restart_next = 1'b1;
        if (!baseTimerRun || !baseOscEnabled) begin
          watchdogReset = 1'b1;
          control_next.resetFlag = 1'b1;
          control_next.runawayFlag = 1'b0;
          control_next.start = 1'b0;
        end
      end
    end
  end

  always_comb begin
    // reset and interrupt requests leave as registered pulses
    chipReset_next = watchdogReset;
    interrupt_next = runawayEvent;
    vector_next = `RWD_RUNAWAY_VECTOR;
    seen_next = seen_reg;
    if (sampleStatus) begin
      seen_next = status_reg;
    end
    status_next = status_reg;
    if (readStatus) begin
      status_next = status_reg & ~seen_reg;
    end
    // Set wins over the read clear
    if (runawayEvent) begin
      status_next[`RWD_EVT_RUNAWAY] = 1'b1;
    end
    if (watchdogReset) begin
      status_next[`RWD_EVT_WDRESET] = 1'b1;
    end
    mask_next = mask_reg;
    if (writeMask) begin
      mask_next = link.writeData[`RWD_EVT_W-1:0];
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      control_reg <= rwd_control_type'(`RWD_CONTROL_RESET);
      status_reg <= '0;
      mask_reg <= '0;
      seen_reg <= '0;
      chipReset_reg <= 1'b0;
      interrupt_reg <= 1'b0;
      vector_reg <= 24'h00_0000;
      irq_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      control_reg <= control_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      seen_reg <= seen_next;
      chipReset_reg <= chipReset_next;
      interrupt_reg <= interrupt_next;
      vector_reg <= vector_next;
      irq_reg <= irq_next;
      restart_reg <= restart_next;
    end
  end
endmodule

/* File: rwd_tick_counter.sv */
// Base tick prescaler and 3-bit runaway stage counter
`timescale 1ns/1ps
`include "rwd_cfg.svh"
module rwd_tick_counter
  import rwd_pkg::*;
#(
  parameter int PRESCALE_FAST = `RWD_PRESCALE_FAST,
  parameter int PRESCALE_SLOW = `RWD_PRESCALE_SLOW,
  parameter int STAGE_W = `RWD_STAGE_W
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic baseTick,
  rwd_link_if.count link
);
  localparam int PRE_W = $clog2(PRESCALE_SLOW);
  localparam logic [PRE_W-1:0] LAST_FAST = PRE_W'(PRESCALE_FAST - 1);
  localparam logic [PRE_W-1:0] LAST_SLOW = PRE_W'(PRESCALE_SLOW - 1);
  localparam logic [STAGE_W-1:0] STAGE_LAST = '1;

  logic [PRE_W-1:0] prescale_reg;
  logic [PRE_W-1:0] prescale_next;
  logic [STAGE_W-1:0] stage_reg;
  logic [STAGE_W-1:0] stage_next;
  logic overflow_reg;
  logic overflow_next;
  logic [PRE_W-1:0] lastCount;

  assign lastCount = link.fastMode ? LAST_FAST : LAST_SLOW;
  assign link.overflow = overflow_reg;

  always_comb begin
    prescale_next = prescale_reg;
    stage_next = stage_reg;
    overflow_next = 1'b0;
    if (link.restart || !link.running) begin
      prescale_next = '0;
      stage_next = '0;
    end else if (link.tickEnable && baseTick) begin
      if (prescale_reg == lastCount) begin
        prescale_next = '0;
        stage_next = stage_reg + 1'b1;
        overflow_next = (stage_reg == STAGE_LAST);
      end else begin
        prescale_next = prescale_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prescale_reg <= '0;
      stage_reg <= '0;
      overflow_reg <= 1'b0;
    end else begin
      prescale_reg <= prescale_next;
      stage_reg <= stage_next;
      overflow_reg <= overflow_next;
    end
  end
endmodule

/* File: testbench.sv */
// Register-level testbench for the runaway watchdog
`timescale 1ns/1ps
`include "rwd_cfg.svh"
module testbench;
  localparam logic [15:0] CT = `RWD_OFS_CONTROL;
  localparam logic [15:0] CLR = `RWD_OFS_CLEAR;
  localparam logic [15:0] STS = `RWD_OFS_IRQ_STATUS;
  localparam logic [15:0] MSK = `RWD_OFS_IRQ_MASK;
  logic clock, reset, avsRead, avsWrite, avsWaitrequest, baseTick;
  logic baseTimerRun, baseOscEnabled, baseFastSelect, standbyEnter;
  logic resetInstruction, chipResetRequest, runawayInterrupt, irq;
  logic [15:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata;
  logic [3:0] avsByteenable;
  logic [1:0] baseCountSelect;
  logic [23:0] runawayVector;
  logic [2:0] tbl [5] = '{3'b100, 3'b101, 3'b110, 3'b111, 3'b000};
  int errors = 0, checked = 0, cyc = 0, nRes = 0, nInt = 0;
  int tInt = 0, pInt = 0, n, i;
  rwd_runaway_watchdog #(.PRESCALE_FAST(4), .PRESCALE_SLOW(8)) dut_u (
    .clock(clock), .reset(reset), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .baseTick(baseTick),
    .baseTimerRun(baseTimerRun), .baseOscEnabled(baseOscEnabled),
    .baseFastSelect(baseFastSelect), .baseCountSelect(baseCountSelect),
    .standbyEnter(standbyEnter), .resetInstruction(resetInstruction),
    .chipResetRequest(chipResetRequest),
    .runawayInterrupt(runawayInterrupt), .runawayVector(runawayVector),
    .irq(irq));
  rwd_base_model tick_u (.clock(clock), .reset(reset), .run(baseTimerRun),
    .baseTick(baseTick));
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  // Pulse counts and interrupt times in cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (chipResetRequest === 1'b1) nRes <= nRes + 1;
    if (runawayInterrupt === 1'b1) begin
      nInt <= nInt + 1;
      pInt <= tInt;
      tInt <= cyc;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge clock); while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic pulse(input logic sb);
    @(posedge clock);
    standbyEnter <= sb;
    resetInstruction <= !sb;
    @(posedge clock);
    standbyEnter <= 1'b0;
    resetInstruction <= 1'b0;
  endtask
  task automatic waitInt();
    int s;
    s = nInt;
    repeat (300) begin
      @(posedge clock);
      if (nInt != s) break;
    end
  endtask
  task finish_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    finish_test;
  end
  initial begin
    {avsRead, avsWrite, standbyEnter, resetInstruction} = 4'h0;
    {baseTimerRun, baseFastSelect, baseCountSelect} = 4'h0;
    avsAddress = 16'h0000;
    avsWritedata = 32'h0000_0000;
    avsByteenable = 4'h1;
    baseOscEnabled = 1'b1;
    reset = 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(CT, 32'h0000_0000);
    rd(16'h7f00, 32'h0000_0000);
    wr(CT, 32'h0000_002c);
    rd(CT, 32'h0000_002c);
    // Improper start: timer stopped, then oscillator off
    for (i = 0; i < 2; i++) begin
      wr(CT, 32'h0000_0000);
      baseTimerRun <= i[0];
      baseOscEnabled <= !i[0];
      n = nRes;
      wr(CT, 32'h0000_0001);
      repeat (3) @(posedge clock);
      chk(nRes - n, 1);
      rd(CT, 32'h0000_0010);
    end
    baseTimerRun <= 1'b1;
    baseOscEnabled <= 1'b1;
    wr(CT, 32'h0000_0001);
    for (i = 0; i < 5; i++) begin
      {baseFastSelect, baseCountSelect} <= tbl[i];
      waitInt();
      waitInt();
      chk(tInt - pInt, (tbl[i][2] && !tbl[i][1]) ? 64 : 128);
    end
    chk(irq, 1'b0);
    rd(CT, 32'h0000_0003);
    wr(MSK, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1);
    rd(STS, 32'h0000_0003);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    wr(CT, 32'h0000_0000);
    rd(CT, 32'h0000_0003);
    n = nInt;
    repeat (4) begin
      repeat (60) @(posedge clock);
      wr(CLR, 32'h0000_0001);
    end
    baseTimerRun <= 1'b0;
    repeat (300) @(posedge clock);
    chk(nInt - n, 0);
    pulse(1'b0);
    rd(CT, 32'h0000_0000);
    baseTimerRun <= 1'b1;
    n = nRes;
    wr(CT, 32'h0000_002d);
    repeat (200) @(posedge clock);
    chk(nRes - n, 1);
    rd(CT, 32'h0000_003c);
    wr(CT, 32'h0000_0009);
    pulse(1'b1);
    rd(CT, 32'h0000_0008);
    wr(CT, 32'h0000_0001);
    pulse(1'b1);
    rd(CT, 32'h0000_0001);
    finish_test;
  end
endmodule
